// [dv/proximity_threshold_status_regs_tb.sv]
//==========================================================================
// Self-checking bench for the threshold and status register bank
module proximity_threshold_status_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys;
  logic        rst;
  logic        spi_sclk;
  logic        spi_csb_n;
  logic        spi_sdi;
  logic        spi_sdo;
  logic        spi_sdo_oe;
  logic [15:0] conv_result;
  logic        conv_done;
  logic        osc_stopped;
  logic [15:0] high_threshold;
  logic        event_out_low;
  logic        power_state_sel;
  logic [15:0] lower_trip_level;
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic [15:0] lfsr = 16'h0063;
  // Reference model state
  int m_low, m_stage, m_mode, m_pwr, m_pend, m_pval, m_lat;
  int m_cmp = 1, m_wake = 1, m_rdy = 1, m_osc = 0;
  // Legal source codes only; reserved codes are never written by a host
  int modes[8] = '{1, 0, 2, 4, 1, 4, 2, 0};

  pts_regs pts_regs_inst (
    .clk_sys(clk_sys), .rst(rst), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .conv_result(conv_result),
    .conv_done(conv_done), .osc_stopped(osc_stopped),
    .high_threshold(high_threshold), .event_out_low(event_out_low),
    .power_state_sel(power_state_sel),
    .lower_trip_level(lower_trip_level));

  pts_host pts_host_inst (
    .clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

  //========================================================================
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  //========================================================================
  // Helpers
  // Next pseudo-random word
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Expected read byte from the model
  function automatic logic [7:0] exp_rd(input logic [6:0] ofs);
    case (ofs)
      pts_pkg::OFS_LOW_LSB:  return 8'(m_low);
      pts_pkg::OFS_LOW_MSB:  return 8'(m_low >> 8);
      pts_pkg::OFS_EVT_CFG:  return 8'(m_mode);
      pts_pkg::OFS_PWR_CFG:  return 8'(m_pwr);
      pts_pkg::OFS_FLAGS:
        return 8'((m_osc << 7) | (m_rdy << 6) | (m_wake << 5) | (m_cmp << 4));
      pts_pkg::OFS_PROX_LSB: return 8'(m_lat);
      pts_pkg::OFS_PROX_MSB: return 8'(m_lat >> 8);
      default:               return pts_pkg::UNMAPPED_RD;
    endcase
  endfunction

  // Expected event pin level
  function automatic logic pin_exp();
    case (3'(m_mode))
      pts_pkg::MODE_WAKE: return 1'(m_wake);
      pts_pkg::MODE_CMP:  return 1'(m_cmp);
      pts_pkg::MODE_RDY:  return 1'(m_rdy);
      default:            return 1'b1;
    endcase
  endfunction

  // Register write through the serial port, model follows
  task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
    logic [7:0] unused;
    pts_host_inst.xfer(1'b0, ofs, d, unused);
    case (ofs)
      pts_pkg::OFS_LOW_LSB: m_stage = d;
      pts_pkg::OFS_LOW_MSB: m_low = (int'(d) << 8) | m_stage;
      pts_pkg::OFS_EVT_CFG: begin
        m_mode = d[2:0];
        if (m_mode != 1) m_wake = 1;
      end
      pts_pkg::OFS_PWR_CFG: m_pwr = d[0];
      default: ;
    endcase
  endtask

  // Register read and compare; low nibble of flags is ignored
  task automatic rchk(input logic [6:0] ofs);
    logic [7:0] d;
    pts_host_inst.xfer(1'b1, ofs, 8'h00, d);
    if (ofs == pts_pkg::OFS_PROX_LSB && m_pend == 1) begin
      m_lat  = m_pval;
      m_pend = 0;
      m_rdy  = 1;
    end
    if (ofs == pts_pkg::OFS_FLAGS) d[3:0] = 4'h0;
    chk($sformatf("read %h", ofs), {8'h00, d}, {8'h00, exp_rd(ofs)});
  endtask

  // One conversion pulse, model updates flags
  task automatic conv(input logic [15:0] r);
    @(posedge clk_sys);
    #1;
    conv_result = r;
    conv_done   = 1'b1;
    @(posedge clk_sys);
    #1;
    conv_done = 1'b0;
    m_pend = 1;
    m_pval = r;
    m_rdy  = 0;
    if (int'(r) > int'(high_threshold)) m_cmp = 0;
    else if (int'(r) < m_low) m_cmp = 1;
    // wake flag follows each result while in wake mode
    if (m_mode == 1) m_wake = (int'(r) > int'(high_threshold)) ? 0 : 1;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // Set the low threshold: low byte staged first
  task automatic set_low(input logic [15:0] v);
    wr(pts_pkg::OFS_LOW_LSB, v[7:0]);
    wr(pts_pkg::OFS_LOW_MSB, v[15:8]);
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  //========================================================================
  // Watchdog
  initial begin
    #900_000;
    error_cnt++;
    wrap_up();
  end

  //========================================================================
  // Main sequence
  initial begin
    logic [15:0] v;
    rst = 1'b1;
    conv_result = 16'h0000;
    conv_done = 1'b0;
    osc_stopped = 1'b0;
    // high level arrives whole, already committed
    high_threshold = 16'h8000;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    // Reset values and unmapped place
    chk("low level", lower_trip_level, 16'h0000);  // committed zero
    chk("power", {15'h0000, power_state_sel}, 16'h0000);  // standby reset
    chk("pin", {15'h0000, event_out_low}, 16'h0001);  // pin off
    rchk(pts_pkg::OFS_PWR_CFG);  // reset zero
    rchk(pts_pkg::OFS_EVT_CFG);  // all disabled
    wr(7'h30, 8'h5a);
    rchk(7'h30);  // unmapped reads zero
    $display("test reset done");
    // Staged low threshold, one pass of slow frames
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      pts_host_inst.half_cyc = (i == 2) ? 25 : 10;
      wr(pts_pkg::OFS_LOW_LSB, v[7:0]);
      rchk(pts_pkg::OFS_LOW_LSB);  // committed byte
      chk("low held", lower_trip_level, 16'(m_low));  // staged only
      wr(pts_pkg::OFS_LOW_MSB, v[15:8]);
      chk("low commit", lower_trip_level, v);  // one step
      rchk(pts_pkg::OFS_LOW_MSB);  // high byte
      rchk(pts_pkg::OFS_LOW_LSB);  // committed byte
    end
    pts_host_inst.half_cyc = 10;
    $display("test threshold done");
    // Power state bit
    wr(pts_pkg::OFS_PWR_CFG, 8'h01);
    chk("power", {15'h0000, power_state_sel}, 16'h0001);  // power bit
    rchk(pts_pkg::OFS_PWR_CFG);  // power bit
    wr(pts_pkg::OFS_PWR_CFG, 8'h00);
    chk("power", {15'h0000, power_state_sel}, 16'h0000);  // power bit
    $display("test power done");
    // Results, latching and flags
    set_low(16'h1000);
    conv(16'h9abc);
    rchk(pts_pkg::OFS_FLAGS);  // flags
    conv(16'h0123);
    rchk(pts_pkg::OFS_PROX_LSB);  // latest byte
    rchk(pts_pkg::OFS_PROX_MSB);  // high byte
    rchk(pts_pkg::OFS_FLAGS);  // ready cleared
    conv(16'h5000);
    rchk(pts_pkg::OFS_FLAGS);  // comparator holds
    rchk(pts_pkg::OFS_PROX_MSB);  // no latch yet
    rchk(pts_pkg::OFS_PROX_LSB);  // latch on read
    rchk(pts_pkg::OFS_PROX_MSB);  // high byte
    osc_stopped = 1'b1;
    m_osc = 1;
    rchk(pts_pkg::OFS_FLAGS);  // oscillator stopped
    osc_stopped = 1'b0;
    m_osc = 0;
    rchk(pts_pkg::OFS_FLAGS);  // oscillator running
    for (int i = 0; i < 5; i++) begin
      conv(rnd());
      rchk(pts_pkg::OFS_FLAGS);  // flags
      rchk(pts_pkg::OFS_PROX_LSB);  // result byte
      rchk(pts_pkg::OFS_PROX_MSB);  // high byte
    end
    $display("test results done");
    // Event pin sources, every legal code
    conv(16'h9000);
    foreach (modes[i]) begin
      wr(pts_pkg::OFS_EVT_CFG, {5'h00, 3'(modes[i])});
      if (modes[i] == 1) begin
        conv(16'h9100);
        rchk(pts_pkg::OFS_FLAGS);  // wake triggered
      end
      chk("pin", {15'h0000, event_out_low},
          {15'h0000, pin_exp()});  // source
      rchk(pts_pkg::OFS_EVT_CFG);  // mode readback
      if (modes[i] == 4) begin
        rchk(pts_pkg::OFS_PROX_LSB);  // latch on read
        chk("pin", {15'h0000, event_out_low}, 16'h0001);  // ready cleared
      end
    end
    rchk(pts_pkg::OFS_FLAGS);  // wake disabled
    $display("test event pin done");
    wrap_up();
  end
endmodule // proximity_threshold_status_regs_tb

// [dv/pts_host.sv]
//==========================================================================
// Host microcontroller model: serial master, mode 0, 16-bit frames
module pts_host (
  input  wire logic clk_sys,     // System clock
  output logic      spi_sclk,    // Serial clock to device
  output logic      spi_csb_n,   // Chip select, low active
  output logic      spi_sdi,     // Data to device
  input  wire logic spi_sdo,     // Data from device
  input  wire logic spi_sdo_oe   // Device drive enable
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half period of sclk in system clocks, raised for slow frames
  int half_cyc = 10;

  // Idle levels at time zero
  initial begin
    spi_sclk  = 1'b0;
    spi_csb_n = 1'b1;
    spi_sdi   = 1'b0;
  end

  // Wait whole clocks, then step off the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One frame: rw bit, offset, data; read byte sampled on rises 9..16
  task automatic xfer(input logic rd, input logic [6:0] ofs,
                      input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] frm;
    frm  = {rd, ofs, wd};
    rdat = 8'h00;
    wait_clk(1);
    spi_csb_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = frm[i];
      wait_clk(half_cyc);
      spi_sclk = 1'b1;
      if (i < 8 && spi_sdo_oe === 1'b1) rdat[i] = spi_sdo;
      wait_clk(half_cyc);
      spi_sclk = 1'b0;
    end
    wait_clk(half_cyc);
    spi_csb_n = 1'b1;
    // Data line flipped after the frame: no stale level
    spi_sdi = ~spi_sdi;
    wait_clk(12);
  endtask
endmodule // pts_host

// [rtl/pts_acc_if.sv]
//==========================================================================
// Register access between serial front end and register core
interface pts_acc_if;
  logic       wr_stb;    // Write pulse
  logic       rd_start;  // Read start pulse
  logic [6:0] addr;      // Register offset
  logic [7:0] wdata;     // Write byte
  logic [7:0] rdata;     // Read byte, valid one cycle after rd_start
  modport front (output wr_stb, output rd_start, output addr,
                 output wdata, input rdata);
  modport core  (input wr_stb, input rd_start, input addr,
                 input wdata, output rdata);
endinterface : pts_acc_if

// [rtl/pts_pkg.sv]
//==========================================================================
// Overview of operation
// - Low LSB buffers; reads committed low byte
// - MSB write commits staged LSB plus MSB
// - MSB read returns committed bits 15:8
// - Mode 100 drives sample-ready onto event pin
// - Mode 010 drives comparator onto event pin
// - Mode 001 drives wake-up onto event pin
// - Mode 000 disables pin; others reserved
// - Power bit resets zero, standby
// - Flags read-only, low nibble meaningless
// - Bit 7 set when oscillator stopped
// - Bit 6 low when new result waits
// - Bit 5 low when wake-up triggered
// - Bit 4: 0 above high, 1 below low
// - Proximity LSB returns latched result byte
// - Results latch only at proximity-LSB read
// - Proximity MSB readable at next offset
//==========================================================================
package pts_pkg;

  //========================================================================
  // Widths
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int RES_W  = 16;

  //========================================================================
  // Register offsets
  localparam logic [6:0] OFS_LOW_LSB  = 7'h08;
  localparam logic [6:0] OFS_LOW_MSB  = 7'h09;
  localparam logic [6:0] OFS_EVT_CFG  = 7'h0a;
  localparam logic [6:0] OFS_PWR_CFG  = 7'h0b;
  localparam logic [6:0] OFS_FLAGS    = 7'h20;
  localparam logic [6:0] OFS_PROX_LSB = 7'h21;
  localparam logic [6:0] OFS_PROX_MSB = 7'h22;

  //========================================================================
  // Event pin source codes
  localparam logic [2:0] MODE_OFF  = 3'h0;
  localparam logic [2:0] MODE_WAKE = 3'h1;
  localparam logic [2:0] MODE_CMP  = 3'h2;
  localparam logic [2:0] MODE_RDY  = 3'h4;

  //========================================================================
  // Field positions
  localparam int FLG_OSC_BIT  = 7;
  localparam int FLG_RDY_BIT  = 6;
  localparam int FLG_WAKE_BIT = 5;
  localparam int FLG_CMP_BIT  = 4;
  localparam int PWR_SEL_BIT  = 0;
  localparam logic [3:0] FLG_LOW_NIBBLE = 4'h0;

  //========================================================================
  // Reset values
  localparam logic [15:0] LOW_THR_RST = 16'h0000;
  localparam logic [7:0]  STAGE_RST   = 8'h00;
  localparam logic [2:0]  EVT_CFG_RST = 3'h0;
  localparam logic        PWR_RST     = 1'h0;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;

  //========================================================================
  // Serial frame layout
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [4:0] HDR_LAST_BIT = 5'h07;
  localparam logic [4:0] DAT_LAST_BIT = 5'h0f;
  localparam logic [4:0] DAT_FIRST    = 5'h08;
  localparam logic [2:0] PIN_IDLE     = 3'h1;

endpackage : pts_pkg

// [rtl/pts_regs.sv]
//==========================================================================
// Proximity threshold and status register bank
module pts_regs (
  input  wire logic        clk_sys,          // System clock
  input  wire logic        rst,              // Sync reset
  input  wire logic        spi_sclk,         // Serial clock pin
  input  wire logic        spi_csb_n,        // Chip select pin, low
  input  wire logic        spi_sdi,          // Serial data in pin
  output logic             spi_sdo,          // Serial data out pin
  output logic             spi_sdo_oe,       // Data out enable
  input  wire logic [15:0] conv_result,      // New proximity result
  input  wire logic        conv_done,        // Result valid pulse
  input  wire logic        osc_stopped,      // Oscillator stopped
  input  wire logic [15:0] high_threshold,   // Committed high threshold
  output logic             event_out_low,    // Event pin, low active
  output logic             power_state_sel,  // 1 active, 0 standby
  output logic [15:0]      lower_trip_level  // Committed low threshold
);

  typedef struct packed {
    logic [15:0] low_thr;
    logic [7:0]  low_stage;
    logic [2:0]  evt_mode;
    logic        pwr;
    logic [15:0] pend_val;
    logic        pend_ok;
    logic [15:0] latched;
    logic        comp;
    logic        wake_n;
    logic        oscillator_fault_flag;
    logic [7:0]  rdata;
    logic        event_out_low;
    logic        sdo;
    logic        sdo_oe;
  } pts_regs_t;

  pts_regs_t  q_reg;
  pts_regs_t  q_next;
  logic [2:0] pin_filt;
  logic       sdo_bit;
  logic [7:0] flags;
  pts_acc_if  acc ();

  //========================================================================
  // Pin synchroniser, select idles high
  pts_sync #(
    .W       (3),
    .RST_VAL (pts_pkg::PIN_IDLE)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_raw  ({spi_sdi, spi_sclk, spi_csb_n}),
    .pin_filt (pin_filt)
  );

  // Serial front end
  pts_spi u_spi (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sclk    (pin_filt[1]),
    .csb_n   (pin_filt[0]),
    .sdi     (pin_filt[2]),
    .sdo_bit (sdo_bit),
    .acc     (acc.front)
  );

  // Matches a decoded access against one offset
  function automatic logic hit(input logic stb, input logic [6:0] a,
                               input logic [6:0] ofs);
    hit = stb && (a == ofs);
  endfunction

  //========================================================================
  // Read-only flags byte, low nibble fixed
  // flags byte layout
  always_comb begin
    flags                        = {4'h0, pts_pkg::FLG_LOW_NIBBLE};
    flags[pts_pkg::FLG_OSC_BIT]  = q_reg.oscillator_fault_flag;
    flags[pts_pkg::FLG_RDY_BIT]  = ~q_reg.pend_ok;
    flags[pts_pkg::FLG_WAKE_BIT] = q_reg.wake_n;
    flags[pts_pkg::FLG_CMP_BIT]  = q_reg.comp;
  end

  //========================================================================
  // Register core next state
  always_comb begin
    q_next                       = q_reg;
    q_next.oscillator_fault_flag = osc_stopped;
    q_next.sdo                   = sdo_bit;
    q_next.sdo_oe                = ~pin_filt[0];

    if (hit(acc.wr_stb, acc.addr, pts_pkg::OFS_LOW_LSB)) begin
      q_next.low_stage = acc.wdata;
    end
    if (hit(acc.wr_stb, acc.addr, pts_pkg::OFS_LOW_MSB)) begin
      q_next.low_thr = {acc.wdata, q_reg.low_stage};
    end
    if (hit(acc.wr_stb, acc.addr, pts_pkg::OFS_EVT_CFG)) begin
      q_next.evt_mode = acc.wdata[2:0];
    end
    if (hit(acc.wr_stb, acc.addr, pts_pkg::OFS_PWR_CFG)) begin
      q_next.pwr = acc.wdata[pts_pkg::PWR_SEL_BIT];
    end

    // Read data mux
    if (acc.rd_start) begin
      unique case (acc.addr)
        pts_pkg::OFS_LOW_LSB:  q_next.rdata = q_reg.low_thr[7:0];
        pts_pkg::OFS_LOW_MSB:  q_next.rdata = q_reg.low_thr[15:8];
        pts_pkg::OFS_EVT_CFG:  q_next.rdata = {5'h00, q_reg.evt_mode};
        pts_pkg::OFS_PWR_CFG:  q_next.rdata = {7'h00, q_reg.pwr};
        pts_pkg::OFS_FLAGS:    q_next.rdata = flags;
        pts_pkg::OFS_PROX_LSB: q_next.rdata = q_reg.pend_val[7:0];
        pts_pkg::OFS_PROX_MSB: q_next.rdata = q_reg.latched[15:8];
        default:               q_next.rdata = pts_pkg::UNMAPPED_RD;
      endcase
    end

    if (hit(acc.rd_start, acc.addr, pts_pkg::OFS_PROX_LSB)) begin
      q_next.latched = q_reg.pend_val;
      q_next.pend_ok = 1'b0;
    end

    // New conversion; its set beats the read clear
    if (conv_done) begin
      q_next.pend_val = conv_result;
      q_next.pend_ok  = 1'b1;
      if (conv_result > high_threshold) begin
        q_next.comp = 1'b0;
      end else if (conv_result < q_reg.low_thr) begin
        q_next.comp = 1'b1;
      end
      q_next.wake_n = ~(conv_result > high_threshold);
    end
    if (q_reg.evt_mode != pts_pkg::MODE_WAKE) begin
      q_next.wake_n = 1'b1;
    end

    // Event pin source select
    unique case (q_reg.evt_mode)
      pts_pkg::MODE_RDY:  q_next.event_out_low = ~q_reg.pend_ok;
      pts_pkg::MODE_CMP:  q_next.event_out_low = q_reg.comp;
      pts_pkg::MODE_WAKE: q_next.event_out_low = q_reg.wake_n;
      default:            q_next.event_out_low = 1'b1;
    endcase
  end

  //========================================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_reg               <= '0;
      q_reg.low_thr       <= pts_pkg::LOW_THR_RST;
      q_reg.low_stage     <= pts_pkg::STAGE_RST;
      q_reg.evt_mode      <= pts_pkg::EVT_CFG_RST;
      q_reg.pwr           <= pts_pkg::PWR_RST;
      q_reg.comp          <= 1'b1;
      q_reg.wake_n        <= 1'b1;
      q_reg.event_out_low <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign acc.rdata        = q_reg.rdata;
  assign spi_sdo          = q_reg.sdo;
  assign spi_sdo_oe       = q_reg.sdo_oe;
  assign event_out_low    = q_reg.event_out_low;
  assign power_state_sel  = q_reg.pwr;
  assign lower_trip_level = q_reg.low_thr;

  //========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_LOW_COMMIT: assert property (
    hit(acc.wr_stb, acc.addr, pts_pkg::OFS_LOW_MSB) |=>
      lower_trip_level == {$past(acc.wdata), $past(q_reg.low_stage)})
    else $error("low threshold commit wrong");

  AST_STAGE_ONLY: assert property (
    hit(acc.wr_stb, acc.addr, pts_pkg::OFS_LOW_LSB) |=>
      $stable(lower_trip_level) && q_reg.low_stage == $past(acc.wdata))
    else $error("low byte write leaked into threshold");

  AST_RD_LOW_LSB: assert property (
    hit(acc.rd_start, acc.addr, pts_pkg::OFS_LOW_LSB) |=>
      acc.rdata == $past(q_reg.low_thr[7:0]))
    else $error("low byte read not committed value");

  AST_RD_LOW_MSB: assert property (
    hit(acc.rd_start, acc.addr, pts_pkg::OFS_LOW_MSB) |=>
      acc.rdata == $past(q_reg.low_thr[15:8]))
    else $error("high byte read wrong");

  AST_EVT_RDY: assert property (
    q_reg.evt_mode == pts_pkg::MODE_RDY |=>
      event_out_low == !$past(q_reg.pend_ok))
    else $error("event pin not sample ready");

  AST_EVT_CMP: assert property (
    q_reg.evt_mode == pts_pkg::MODE_CMP |=>
      event_out_low == $past(q_reg.comp))
    else $error("event pin not comparator");

  AST_EVT_WAKE: assert property (
    q_reg.evt_mode == pts_pkg::MODE_WAKE |=>
      event_out_low == $past(q_reg.wake_n))
    else $error("event pin not wake-up");

  AST_EVT_OFF: assert property (
    (q_reg.evt_mode == pts_pkg::MODE_OFF)[*2] |-> event_out_low)
    else $error("event pin active while disabled");

  AST_XFER: assert property (
    hit(acc.rd_start, acc.addr, pts_pkg::OFS_PROX_LSB) && !conv_done |=>
      q_reg.latched == $past(q_reg.pend_val) && !q_reg.pend_ok)
    else $error("result transfer wrong");

  AST_LATCH_HOLD: assert property (
    !hit(acc.rd_start, acc.addr, pts_pkg::OFS_PROX_LSB) |=>
      $stable(q_reg.latched))
    else $error("latched result moved without read");

  AST_CMP_HOLD: assert property (
    conv_done && conv_result <= high_threshold &&
    conv_result >= q_reg.low_thr |=> $stable(q_reg.comp))
    else $error("comparator moved inside band");

endmodule // pts_regs

// [rtl/pts_spi.sv]
//==========================================================================
// Serial peripheral front end, mode 0, 16-bit frames
module pts_spi (
  input  wire logic clk_sys,         // System clock
  input  wire logic rst,             // Sync reset
  input  wire logic sclk,            // Filtered serial clock
  input  wire logic csb_n,           // Filtered chip select, low active
  input  wire logic sdi,             // Filtered serial data in
  output logic      sdo_bit,         // Serial data out bit
  pts_acc_if.front  acc              // Register access
);

  typedef struct packed {
    logic       sclk_d;
    logic [4:0] cnt;
    logic [7:0] rx;
    logic       is_rd;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] tx;
    logic [1:0] load_pend;
    logic       sdo;
    logic       wr_stb;
    logic       rd_start;
  } pts_spi_t;

  pts_spi_t q_reg;
  pts_spi_t q_next;
  logic     rise;
  logic     fall;

  // Serial clock edges
  assign rise = sclk & ~q_reg.sclk_d;
  assign fall = ~sclk & q_reg.sclk_d;

  //========================================================================
  // Frame: read flag, 7-bit offset, 8 data bits, MSB first
  always_comb begin
    q_next           = q_reg;
    q_next.sclk_d    = sclk;
    q_next.wr_stb    = 1'b0;
    q_next.rd_start  = 1'b0;
    q_next.load_pend = {q_reg.load_pend[0], 1'b0};
    if (csb_n) begin
      q_next.cnt       = 5'h00;
      q_next.load_pend = 2'h0;
    end else begin
      // Read byte arrives two cycles after the header
      if (q_reg.load_pend[1]) begin
        q_next.tx = acc.rdata;
      end
      if (rise && (q_reg.cnt < pts_pkg::FRAME_BITS)) begin
        q_next.rx  = {q_reg.rx[6:0], sdi};
        q_next.cnt = q_reg.cnt + 5'h01;
        if (q_reg.cnt == pts_pkg::HDR_LAST_BIT) begin
          q_next.is_rd = q_reg.rx[6];
          q_next.addr  = {q_reg.rx[5:0], sdi};
          q_next.tx    = 8'h00;
          if (q_reg.rx[6]) begin
            q_next.rd_start  = 1'b1;
            q_next.load_pend = 2'h1;
          end
        end
        if ((q_reg.cnt == pts_pkg::DAT_LAST_BIT) && !q_reg.is_rd) begin
          q_next.wdata  = {q_reg.rx[6:0], sdi};
          q_next.wr_stb = 1'b1;
        end
      end
      // Shift out on falling edges of the data phase
      if (fall && (q_reg.cnt >= pts_pkg::DAT_FIRST) &&
          (q_reg.cnt < pts_pkg::FRAME_BITS)) begin
        q_next.sdo = q_reg.tx[7];
        q_next.tx  = {q_reg.tx[6:0], 1'b0};
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign acc.wr_stb   = q_reg.wr_stb;
  assign acc.rd_start = q_reg.rd_start;
  assign acc.addr     = q_reg.addr;
  assign acc.wdata    = q_reg.wdata;
  assign sdo_bit      = q_reg.sdo;

endmodule // pts_spi

// [rtl/pts_sync.sv]
//==========================================================================
// Three-stage pin synchroniser with agreement filter
module pts_sync #(
  parameter int         W       = 3,
  parameter logic [2:0] RST_VAL = 3'h0
) (
  input  wire logic         clk_sys,  // System clock
  input  wire logic         rst,      // Sync reset
  input  wire logic [W-1:0] pin_raw,  // Asynchronous pins
  output logic      [W-1:0] pin_filt  // Filtered levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } pts_sync_t;

  pts_sync_t q_reg;
  pts_sync_t q_next;

  //========================================================================
  // Filter takes a level once stages two and three agree
  always_comb begin
    q_next      = q_reg;
    q_next.s1   = pin_raw;
    q_next.s2   = q_reg.s1;
    q_next.s3   = q_reg.s2;
    q_next.filt = (q_reg.s2 & q_reg.s3) |
                  (q_reg.filt & (q_reg.s2 ^ q_reg.s3));
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_reg <= {4{RST_VAL[W-1:0]}};
    end else begin
      q_reg <= q_next;
    end
  end

  assign pin_filt = q_reg.filt;

endmodule // pts_sync
